/* core/wit_watchdog_interval_timer.sv */
// Watchdog / interval timer with its Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Three-bit code picks overflow period
// - Period select byte-written, resets to zero
// - Mode and action bits choose overflow effect
// - Writing run one clears and restarts counter
// - Run bit ignores software writes of zero
// - Mode and action bits stick until reset
// - Mode register byte or bit written, resets zero
// - First overflow after restart exact, not early
// - Counts in halt, stops in stop
// - Counting paused while cpu runs on subclock
// - Interval mode repeats masked, prioritised interrupt
// - Interval request has top default priority
module wit_watchdog_interval_timer #(
  parameter int COUNT_W   = wit_pkg::COUNT_W_DEF,   // Counter width
  parameter int SHIFT_LO  = wit_pkg::SHIFT_LO_DEF,  // Shift for code 0
  parameter int SHIFT_TOP = wit_pkg::SHIFT_TOP_DEF  // Shift for code 7
) (
  input  wire logic        i_core_clk,              // Main clock, 25 MHz
  input  wire logic        i_rst,                   // Sync reset, high
  input  wire logic [17:0] i_avs_address,           // Byte address
  input  wire logic        i_avs_read,              // Read request
  input  wire logic        i_avs_write,             // Write request
  input  wire logic [31:0] i_avs_writedata,         // Write data
  input  wire logic [3:0]  i_avs_byteenable,        // Byte lanes
  input  wire logic        i_stop_mode,             // Device in stop
  input  wire logic        i_cpu_on_subclock,       // Cpu on subclock
  output logic      [31:0] o_avs_readdata,          // Read data
  output logic             o_avs_waitrequest,       // Bus wait
  output logic             o_interval_irq_request,  // Maskable pulse
  output logic             o_interval_irq_priority, // Priority flag
  output logic             o_nmi_request,           // Non-maskable pulse
  output logic             o_system_reset_request,  // Reset pulse
  output logic             o_counting               // Counter advancing
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [2:0]         overflow_sel;       // Period select field
  logic               run;                // Sticky run bit
  logic               guard_mode_sel;     // Sticky watchdog mode
  logic               overflow_action_sel; // Sticky reset-versus-nmi
  logic               interval_irq_mask;  // Interval interrupt mask
  logic               interval_irq_priority; // Interval priority flag
  logic [2:0]         next_overflow_sel;  // Next period select
  logic               next_run;           // Next run bit
  logic               next_guard;         // Next watchdog mode
  logic               next_action;        // Next action select
  logic               next_mask;          // Next mask
  logic               next_prio;          // Next priority
  logic               restart;            // Clear counter this cycle
  logic [31:0]        next_readdata;      // Read mux result
  logic               next_irq;           // Next interval pulse
  logic               next_nmi;           // Next nmi pulse
  logic               next_rst_req;       // Next reset pulse
  logic               next_counting;      // Next counting status
  logic               count_enable;       // Counter advances
  logic               capture;            // Latch read data
  logic               commit;             // Apply write
  logic               overflow;           // Overflow pulse from counter
  logic [COUNT_W-1:0] count;              // Live count
  logic [15:0]        reg_idx;            // Register index from address
  logic               aligned;            // Word-aligned access
  logic               lane0;              // Low byte lane enabled
  logic [7:0]         wbyte;              // Low byte of write data
  logic [7:0]         mode_byte;          // Mode register as read
  wit_pkg::wit_action_t action;           // Current overflow effect

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // One wait cycle per transfer; see the handshake module
  wit_bus_handshake u_handshake (
    .i_core_clk    (i_core_clk),
    .i_rst         (i_rst),
    .i_read        (i_avs_read),
    .i_write       (i_avs_write),
    .o_waitrequest (o_avs_waitrequest),
    .o_capture     (capture),
    .o_commit      (commit)
  );

  // Address split: index in the upper bits, byte offset must be zero
  assign reg_idx = i_avs_address[17:2];
  assign aligned = (i_avs_address[1:0] == 2'h0);
  assign lane0   = i_avs_byteenable[0];
  assign wbyte   = i_avs_writedata[7:0];

  // Mode register image, unused bits read as zero
  always_comb begin
    mode_byte = 8'h00;
    mode_byte[wit_pkg::RUN_BIT]    = run;
    mode_byte[wit_pkg::GUARD_BIT]  = guard_mode_sel;
    mode_byte[wit_pkg::ACTION_BIT] = overflow_action_sel;
  end

  // ==========================================================================
  // Control registers: next values
  // ==========================================================================
  // Bits that software can only set are ORed in, never replaced
  always_comb begin
    next_overflow_sel = overflow_sel;
    next_run          = run;
    next_guard        = guard_mode_sel;
    next_action       = overflow_action_sel;
    next_mask         = interval_irq_mask;
    next_prio         = interval_irq_priority;
    restart           = 1'b0;
    if (commit && aligned && lane0) begin
      if (reg_idx == wit_pkg::OVF_SEL_IDX) begin
        // Whole byte only; taken even while running
        next_overflow_sel = wbyte[wit_pkg::PERIOD_LSB +: wit_pkg::PERIOD_W];
      end else if ((reg_idx == wit_pkg::MODE_IDX) ||
                   (reg_idx == wit_pkg::MODE_SET_IDX)) begin
        // Byte and alias writes alike: bits are set-only
        next_run    = run | wbyte[wit_pkg::RUN_BIT];
        next_guard  = guard_mode_sel | wbyte[wit_pkg::GUARD_BIT];
        next_action = overflow_action_sel |
                      wbyte[wit_pkg::ACTION_BIT];
        restart     = wbyte[wit_pkg::RUN_BIT];
      end else if (reg_idx == wit_pkg::IRQ_CTRL_IDX) begin
        next_mask = wbyte[wit_pkg::IRQ_MASK_BIT];
        next_prio = wbyte[wit_pkg::IRQ_PRIO_BIT];
      end else begin
        // Unmapped or read-only index: write dropped
        next_run = run;
      end
    end
  end

  // Control register storage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      overflow_sel          <= wit_pkg::OVF_SEL_RST[2:0];
      run                   <= wit_pkg::MODE_RST[wit_pkg::RUN_BIT];
      guard_mode_sel        <= wit_pkg::MODE_RST[wit_pkg::GUARD_BIT];
      overflow_action_sel   <= wit_pkg::MODE_RST[wit_pkg::ACTION_BIT];
      interval_irq_mask     <= wit_pkg::IRQ_CTRL_RST[wit_pkg::IRQ_MASK_BIT];
      interval_irq_priority <= wit_pkg::IRQ_CTRL_RST[wit_pkg::IRQ_PRIO_BIT];
    end else begin
      overflow_sel          <= next_overflow_sel;
      run                   <= next_run;
      guard_mode_sel        <= next_guard;
      overflow_action_sel   <= next_action;
      interval_irq_mask     <= next_mask;
      interval_irq_priority <= next_prio;
    end
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Halt has no input, so it counts on; stop and subclock
  // freeze the count without clearing it
  assign count_enable = run && !i_stop_mode && !i_cpu_on_subclock;

  // Restart clears outright: first period exact, not early
  wit_overflow_counter #(
    .COUNT_W   (COUNT_W),
    .SHIFT_LO  (SHIFT_LO),
    .SHIFT_TOP (SHIFT_TOP)
  ) u_counter (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (restart),
    .i_enable   (count_enable),
    .i_sel      (overflow_sel),
    .o_count    (count),
    .o_overflow (overflow)
  );

  // ==========================================================================
  // Overflow effect
  // ==========================================================================
  // Guard bit picks watchdog; then the action bit picks nmi or reset
  always_comb begin
    if (!guard_mode_sel) begin
      action = wit_pkg::WIT_ACT_IRQ;
    end else if (!overflow_action_sel) begin
      action = wit_pkg::WIT_ACT_NMI;
    end else begin
      action = wit_pkg::WIT_ACT_RESET;
    end
  end

  // Route the single overflow pulse to one output at most
  always_comb begin
    next_irq      = 1'b0;
    next_nmi      = 1'b0;
    next_rst_req  = 1'b0;
    next_counting = count_enable;
    case (action)
      wit_pkg::WIT_ACT_IRQ: begin
        // Masked requests are simply dropped, not held pending
        next_irq = overflow && !interval_irq_mask;
      end
      wit_pkg::WIT_ACT_NMI: begin
        next_nmi = overflow;
      end
      wit_pkg::WIT_ACT_RESET: begin
        next_rst_req = overflow;
      end
      default: begin
        next_irq = 1'b0;
      end
    endcase
  end

  // Outputs, all registered; the three event outputs are one-cycle pulses
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_interval_irq_request  <= 1'b0;
      o_nmi_request           <= 1'b0;
      o_system_reset_request  <= 1'b0;
      o_interval_irq_priority <= 1'b0;
      o_counting              <= 1'b0;
    end else begin
      o_interval_irq_request  <= next_irq;
      o_nmi_request           <= next_nmi;
      o_system_reset_request  <= next_rst_req;
      // Ranked first by default; the flag picks the level
      o_interval_irq_priority <= interval_irq_priority;
      o_counting              <= next_counting;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Narrow registers sit in the low bits; all else reads zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (!aligned) begin
      next_readdata = 32'h0000_0000;
    end else if (reg_idx == wit_pkg::OVF_SEL_IDX) begin
      next_readdata[2:0] = overflow_sel;
    end else if (reg_idx == wit_pkg::MODE_IDX) begin
      next_readdata[7:0] = mode_byte;
    end else if (reg_idx == wit_pkg::MODE_SET_IDX) begin
      next_readdata[7:0] = mode_byte;
    end else if (reg_idx == wit_pkg::IRQ_CTRL_IDX) begin
      next_readdata[wit_pkg::IRQ_MASK_BIT] = interval_irq_mask;
      next_readdata[wit_pkg::IRQ_PRIO_BIT] = interval_irq_priority;
    end else if (reg_idx == wit_pkg::COUNT_IDX) begin
      next_readdata[COUNT_W-1:0] = count;
    end else begin
      next_readdata = 32'h0000_0000;
    end
  end

  // Latched during the wait cycle, held until the next read
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (capture) begin
      o_avs_readdata <= next_readdata;
    end else begin
      o_avs_readdata <= o_avs_readdata;
    end
  end

endmodule

`default_nettype wire

/* core/wit_pkg.sv */
// Shared constants for the watchdog and interval timer
package wit_pkg;

  // ==========================================================================
  // Register indexes (byte address is four times the index)
  // ==========================================================================
  localparam logic [15:0] OVF_SEL_IDX  = 16'hff42; // Overflow period select
  localparam logic [15:0] MODE_IDX     = 16'hfff9; // Run, guard and action
  localparam logic [15:0] IRQ_CTRL_IDX = 16'hff80; // Interval mask, priority
  localparam logic [15:0] MODE_SET_IDX = 16'hff81; // Single-bit set alias
  localparam logic [15:0] COUNT_IDX    = 16'hff82; // Live counter value

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int RUN_BIT       = 7;   // Run bit of the mode register
  localparam int GUARD_BIT     = 4;   // Watchdog mode select
  localparam int ACTION_BIT    = 3;   // Overflow action: nmi or reset
  localparam int PERIOD_LSB    = 0;   // Period select field, low bit
  localparam int PERIOD_W      = 3;   // Period select field width
  localparam int IRQ_MASK_BIT  = 0;   // Interval interrupt mask
  localparam int IRQ_PRIO_BIT  = 1;   // Interval interrupt priority

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] OVF_SEL_RST  = 8'h00; // Shortest period
  localparam logic [7:0] MODE_RST     = 8'h00; // Stopped, interval mode
  localparam logic [1:0] IRQ_CTRL_RST = 2'h1;  // Masked, low priority

  // ==========================================================================
  // Timing: overflow periods as powers of two of main-clock cycles
  // ==========================================================================
  localparam int SHIFT_LO_DEF  = 12;  // Code 000 gives 2^12 cycles
  localparam int SHIFT_TOP_DEF = 20;  // Code 111 gives 2^20 cycles
  localparam int COUNT_W_DEF   = 20;  // Counter width for 2^20

  // Selected overflow action
  typedef enum logic [1:0] {
    WIT_ACT_IRQ,
    WIT_ACT_NMI,
    WIT_ACT_RESET
  } wit_action_t;

endpackage

/* core/wit_bus_handshake.sv */
// Avalon-MM waitrequest handshake: one wait cycle per transfer
`timescale 1ns/10ps
`default_nettype none

module wit_bus_handshake (
  input  wire logic i_core_clk,   // Main clock
  input  wire logic i_rst,        // Synchronous reset, active high
  input  wire logic i_read,       // Master read request
  input  wire logic i_write,      // Master write request
  output logic      o_waitrequest, // Registered wait to the master
  output logic      o_capture,    // Read data must be latched now
  output logic      o_commit      // Write takes effect at this edge
);

  logic next_waitrequest; // Next wait state

  // ==========================================================================
  // Handshake
  // ==========================================================================
  // Wait drops for exactly one cycle after a request is seen
  always_comb begin
    next_waitrequest = 1'b1;
    if ((i_read || i_write) && o_waitrequest) begin
      next_waitrequest = 1'b0;
    end
  end

  // Read data is latched when taken, so it stands when sampled
  assign o_capture = i_read && o_waitrequest;
  assign o_commit  = i_write && !o_waitrequest;

  // Wait state register, high under reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= next_waitrequest;
    end
  end

endmodule

`default_nettype wire

/* core/wit_overflow_counter.sv */
// Free counter with selectable power-of-two overflow period
`timescale 1ns/10ps
`default_nettype none

module wit_overflow_counter #(
  parameter int COUNT_W   = wit_pkg::COUNT_W_DEF,   // Counter width
  parameter int SHIFT_LO  = wit_pkg::SHIFT_LO_DEF,  // Shift for code 0
  parameter int SHIFT_TOP = wit_pkg::SHIFT_TOP_DEF  // Shift for code 7
) (
  input  wire logic               i_core_clk, // Main clock
  input  wire logic               i_rst,      // Synchronous reset
  input  wire logic               i_clear,    // Restart from zero
  input  wire logic               i_enable,   // Count this cycle
  input  wire logic [2:0]         i_sel,      // Period select code
  output logic      [COUNT_W-1:0] o_count,    // Current count
  output logic                    o_overflow  // One-cycle overflow pulse
);

  logic [COUNT_W-1:0] next_count;    // Next count
  logic               next_overflow; // Next overflow pulse
  logic [COUNT_W-1:0] term_mask;     // Low bits that must all be one
  int                 shift;         // Period as a power of two

  // ==========================================================================
  // Period decode and counting
  // ==========================================================================
  // Code 7 skips to the top power
  always_comb begin
    shift = (i_sel == 3'h7) ? SHIFT_TOP : SHIFT_LO + int'(i_sel);
    term_mask = COUNT_W'((64'h1 << shift) - 64'h1);
    next_count    = o_count;
    next_overflow = 1'b0;
    if (i_clear) begin
      next_count = '0;
    end else if (i_enable) begin
      if ((o_count & term_mask) == term_mask) begin
        // Wrap and keep going, so interval mode repeats
        next_count    = '0;
        next_overflow = 1'b1;
      end else begin
        next_count = o_count + COUNT_W'(1);
      end
    end
  end

  // Count and pulse registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_count    <= '0;
      o_overflow <= 1'b0;
    end else begin
      o_count    <= next_count;
      o_overflow <= next_overflow;
    end
  end

endmodule

`default_nettype wire

/* sim/wit_watchdog_interval_timer_asserts.sv */
// Port-level checker for the watchdog and interval timer
`timescale 1ns/10ps
`default_nettype none

module wit_watchdog_interval_timer_asserts #(
  parameter int COUNT_W   = 20, // Counter width
  parameter int SHIFT_LO  = 12, // Shift for code 0
  parameter int SHIFT_TOP = 20  // Shift for code 7
) (
  input wire logic        i_core_clk,              // Main clock
  input wire logic        i_rst,                   // Sync reset
  input wire logic [17:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        i_stop_mode,
  input wire logic        i_cpu_on_subclock,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_interval_irq_request,
  input wire logic        o_interval_irq_priority,
  input wire logic        o_nmi_request,
  input wire logic        o_system_reset_request,
  input wire logic        o_counting               // Counter advancing
);
  // ==========================================================================
  // Common clock, reset and helpers
  // ==========================================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic hold_cause; // Legal reasons for a pause
  always_comb begin
    hold_cause = i_stop_mode | i_cpu_on_subclock
               | (i_avs_write & ~o_avs_waitrequest);
  end
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_handshake;
    s_taken |=> s_answer;
  endproperty
  property p_wait_cause;
    !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
  endproperty
  property p_rdata_hold;
    !$stable(o_avs_readdata) |-> $fell(o_avs_waitrequest) && $past(i_avs_read);
  endproperty
  property p_irq_pulse;
    o_interval_irq_request |=> !o_interval_irq_request;
  endproperty
  property p_nmi_pulse;
    o_nmi_request |=> !o_nmi_request;
  endproperty
  property p_rreq_pulse;
    o_system_reset_request |=> !o_system_reset_request;
  endproperty
  property p_one_action;
    $onehot0({o_interval_irq_request, o_nmi_request, o_system_reset_request});
  endproperty
  property p_stop_halt;
    i_stop_mode |=> !o_counting;
  endproperty
  property p_sub_halt;
    i_cpu_on_subclock |=> !o_counting;
  endproperty
  property p_run_sticky;
    $fell(o_counting) |-> $past(hold_cause) || $past(hold_cause, 2);
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("bad wait pulse");
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait low, no request");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed off a read");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq pulse too long");
  a_nmi_pulse: assert property (p_nmi_pulse)
    else $error("nmi pulse too long");
  a_rreq_pulse: assert property (p_rreq_pulse)
    else $error("reset pulse too long");
  a_one_action: assert property (p_one_action)
    else $error("two actions at once");
  a_stop_halt: assert property (p_stop_halt)
    else $error("counter advanced in stop");
  a_sub_halt: assert property (p_sub_halt)
    else $error("counter advanced on subclock");
  a_run_sticky: assert property (p_run_sticky)
    else $error("counting stopped with no cause");
endmodule

bind wit_watchdog_interval_timer wit_watchdog_interval_timer_asserts #(
  .COUNT_W(COUNT_W), .SHIFT_LO(SHIFT_LO), .SHIFT_TOP(SHIFT_TOP)
) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .i_stop_mode(i_stop_mode), .i_cpu_on_subclock(i_cpu_on_subclock),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_interval_irq_request(o_interval_irq_request),
  .o_interval_irq_priority(o_interval_irq_priority),
  .o_nmi_request(o_nmi_request), .o_counting(o_counting),
  .o_system_reset_request(o_system_reset_request)
);
`default_nettype wire

/* sim/wit_watchdog_interval_timer_test.sv */
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
`default_nettype none

module wit_watchdog_interval_timer_test;
  // ==========================================================================
  // Stimulus, responses and bookkeeping
  // ==========================================================================
  logic        i_core_clk, i_rst, i_avs_read, i_avs_write;
  logic        i_stop_mode, i_cpu_on_subclock;
  logic [17:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0]  i_avs_byteenable;
  logic        o_avs_waitrequest, o_interval_irq_request;
  logic        o_interval_irq_priority, o_nmi_request;
  logic        o_system_reset_request, o_counting;
  int          fail_count, n_tests, cyc, t_last, gap; // Gap between irqs
  int          n_irq, n_nmi, n_rr, b_irq, b_nmi, b_rr, per;

  // Short periods: code c gives 2^(2+c), code 7 gives 2^10
  wit_watchdog_interval_timer #(.COUNT_W(20), .SHIFT_LO(2), .SHIFT_TOP(10))
  DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .i_stop_mode(i_stop_mode), .i_cpu_on_subclock(i_cpu_on_subclock),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_interval_irq_request(o_interval_irq_request),
    .o_interval_irq_priority(o_interval_irq_priority),
    .o_nmi_request(o_nmi_request), .o_counting(o_counting),
    .o_system_reset_request(o_system_reset_request));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  // Pulse counters and spacing of interval requests
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_interval_irq_request === 1'b1) begin
      n_irq  <= n_irq + 1;
      gap    <= cyc - t_last;
      t_last <= cyc;
    end
    if (o_nmi_request === 1'b1) n_nmi <= n_nmi + 1;
    if (o_system_reset_request === 1'b1) n_rr <= n_rr + 1;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge i_core_clk);
    i_avs_write      <= w;
    i_avs_read       <= ~w;
    i_avs_address    <= {idx, 2'b00};
    i_avs_writedata  <= {24'h0, d};
    i_avs_byteenable <= be;
    do @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [3:0] be = 4'h1);
    logic [31:0] q;
    bus(1'b1, idx, d, be, q);
  endtask

  task automatic rchk(input string nm, input logic [15:0] idx,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 4'hf, q);
    chk(nm, e, q);
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    b_irq = n_irq;
    b_nmi = n_nmi;
    b_rr  = n_rr;
  endtask

  task automatic end_sim();
    $display("TB: checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: all tests need well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge i_core_clk);
    fail_count++;
    end_sim();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    {i_avs_read, i_avs_write, i_stop_mode, i_cpu_on_subclock} = '0;
    i_rst = 1'b1;
    {i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
    {fail_count, n_tests, cyc, t_last, gap, n_irq, n_nmi, n_rr} = '0;
    do_reset();
    // Reset values, unmapped place, lane refusal
    rchk("overflow select", wit_pkg::OVF_SEL_IDX, 32'h0);
    rchk("mode", wit_pkg::MODE_IDX, 32'h0);
    rchk("irq ctrl", wit_pkg::IRQ_CTRL_IDX, 32'h1);
    rchk("unmapped", 16'hff00, 32'h0);
    chk("idle counting", 32'h0, o_counting);
    wr(wit_pkg::OVF_SEL_IDX, 8'h05, 4'h2);
    rchk("lane refused", wit_pkg::OVF_SEL_IDX, 32'h0);
    // Masked interval overflows are dropped
    wr(wit_pkg::MODE_IDX, 8'h80);
    repeat (40) @(posedge i_core_clk);
    chk("masked irqs", b_irq, n_irq);
    wr(wit_pkg::IRQ_CTRL_IDX, 8'h02);
    repeat (40) @(posedge i_core_clk);
    chk("unmasked irqs", 32'h1, n_irq > b_irq);
    chk("priority out", 32'h1, o_interval_irq_priority);
    // Stop, then subclock, freeze the count
    for (int k = 0; k < 2; k++) begin
      wr(wit_pkg::MODE_IDX, 8'h80);
      i_stop_mode       <= (k == 0);
      i_cpu_on_subclock <= (k == 1);
      repeat (4) @(posedge i_core_clk);
      b_irq = n_irq;
      repeat (40) @(posedge i_core_clk);
      chk("frozen irqs", b_irq, n_irq);
      chk("frozen counting", 32'h0, o_counting);
      i_stop_mode       <= 1'b0;
      i_cpu_on_subclock <= 1'b0;
      repeat (40) @(posedge i_core_clk);
      chk("resumed irqs", 32'h1, n_irq > b_irq);
    end
    // Every period code, spacing of repeated requests
    for (int c = 0; c < 8; c++) begin
      do_reset();
      wr(wit_pkg::OVF_SEL_IDX, 8'(c));
      wr(wit_pkg::IRQ_CTRL_IDX, 8'h00);
      wr(wit_pkg::MODE_IDX, 8'h80);
      per = (c == 7) ? 1024 : (4 << c);
      repeat (3 * per + 8) @(posedge i_core_clk);
      chk("interval gap", per, gap);
    end
    // Watchdog with nmi: refreshed, then starved
    do_reset();
    wr(wit_pkg::OVF_SEL_IDX, 8'h02);
    wr(wit_pkg::IRQ_CTRL_IDX, 8'h00);
    wr(wit_pkg::MODE_SET_IDX, 8'h10);
    for (int r = 0; r < 10; r++) begin
      wr(wit_pkg::MODE_IDX, 8'h80);
      repeat (4) @(posedge i_core_clk);
    end
    chk("refreshed nmi", b_nmi, n_nmi);
    repeat (40) @(posedge i_core_clk);
    chk("starved nmi", 32'h1, n_nmi > b_nmi);
    chk("no irq in guard", b_irq, n_irq);
    chk("no reset req", b_rr, n_rr);
    wr(wit_pkg::MODE_IDX, 8'h00);
    rchk("sticky mode", wit_pkg::MODE_IDX, 32'h90);
    // Watchdog with reset action, then reset clears the mode
    do_reset();
    wr(wit_pkg::MODE_IDX, 8'h98);
    repeat (20) @(posedge i_core_clk);
    chk("reset req", 32'h1, n_rr > b_rr);
    chk("no nmi", b_nmi, n_nmi);
    do_reset();
    rchk("mode after reset", wit_pkg::MODE_IDX, 32'h0);
    rchk("count after reset", wit_pkg::COUNT_IDX, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
